//--- src/poadc_output_port.sv
// Digital output port of a 10-bit pipelined converter: pipeline, correction, bus drive
//
// Notes on behaviour
// - Code appears 5.5 clocks after sample.
// - Samples are captured on falling clock edge.
// - Output word valid at rising clock edge.
// - Ten stages, one stage per half cycle.
// - Correction merges redundant 1.5-bit decisions.
// - Straight offset binary, zero is midscale.
// - Minus one LSB gives 01 1111 1111.
// - Bus bit 9 is MSB, bit 0 LSB.
// - Sleep request high powers down conversion.
// - Drive enable low drives, high disables.
// - Both pins high floats the data bus.
// - Enable low during sleep holds last word.
`timescale 1ns/1ps
module poadc_output_port
   import poadc_pkg::*;
(
   input  wire logic                     core_clk,        // Conversion clock, 50 MHz
   input  wire logic                     rstn,            // Synchronous reset, active low
   input  wire poadc_pkg::poadc_dec_t    stage_dec,       // Stage quantizer decisions, async to clock
   input  wire logic                     sleep_request,   // Power-down request pin, high = sleep
   input  wire logic                     drive_en_n,      // Output drive enable pin, active low
   output logic [poadc_pkg::CODE_W-1:0]  sample_code_bus, // Output code, bit 9 MSB
   output logic [poadc_pkg::CODE_W-1:0]  sample_code_oe_n,// Per-bit drive enable, low = driving
   output logic                          sample_valid     // Word on bus belongs to a filled pipeline
);
   import poadc_pkg::*;

   // Correction: sum decisions weighted by stage position, offset into binary
   function automatic logic [CODE_W-1:0] poadc_correct(input poadc_dec_t d);
      logic [CODE_W+1:0] acc;
      acc = {2'h0, CODE_RESET};
      for (int i = 0; i < NUM_STAGES; i++) begin
         if (d[i] == DEC_HIGH) begin
            acc = acc + ((CODE_W+2)'(1) << (NUM_STAGES - 1 - i));
         end else if (d[i] == DEC_LOW) begin
            acc = acc - ((CODE_W+2)'(1) << (NUM_STAGES - 1 - i));
         end
      end
      // Clip so every code between the rails stays reachable
      if (acc[CODE_W+1]) begin
         return '0;
      end else if (acc[CODE_W]) begin
         return '1;
      end
      return acc[CODE_W-1:0];
   endfunction

   // Pin synchronisers, two flops each
   logic [1:0]  sleep_sync_reg, sleep_sync_next;
   logic [1:0]  oen_sync_reg, oen_sync_next;
   poadc_dec_t  dec_s1_reg, dec_s1_next, dec_s2_reg, dec_s2_next;

   always_comb begin
      sleep_sync_next = {sleep_sync_reg[0], sleep_request};
      oen_sync_next   = {oen_sync_reg[0], drive_en_n};
      dec_s1_next     = stage_dec;
      dec_s2_next     = dec_s1_reg;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sleep_sync_reg <= 2'h0;
         oen_sync_reg   <= 2'h3;
         dec_s1_reg     <= '0;
         dec_s2_reg     <= '0;
      end else begin
         sleep_sync_reg <= sleep_sync_next;
         oen_sync_reg   <= oen_sync_next;
         dec_s1_reg     <= dec_s1_next;
         dec_s2_reg     <= dec_s2_next;
      end
   end

   logic sleep_s;
   logic oen_s;
   assign sleep_s = sleep_sync_reg[1];
   assign oen_s   = oen_sync_reg[1];

   // Mode decode from synchronised pins
   poadc_mode_t mode;
   always_comb begin
      if (sleep_s && oen_s) begin
         mode = POADC_FLOAT;
      end else if (sleep_s) begin
         mode = POADC_HOLD;
      end else begin
         mode = POADC_RUN;
      end
   end

   // Falling-edge sample capture, the first half-cycle stage
   poadc_smp_t fall_reg, fall_next;
   always_comb begin
      fall_next.valid = !sleep_s;
      fall_next.dec   = dec_s2_reg;
   end

   always_ff @(negedge core_clk) begin
      if (!rstn) begin
         fall_reg <= '0;
      end else begin
         fall_reg <= fall_next;
      end
   end

   // Half-cycle pipeline: odd steps on falling edge, even steps on rising edge.
   // Stage 1 is fall_reg; stages 2..LAT_HALF-1 alternate edges.
   localparam int unsigned RISE_N = LAT_HALF / 2;           // Rising-edge stages
   localparam int unsigned FALL_N = LAT_HALF / 2 - 1;       // Further falling-edge stages
   poadc_smp_t rise_reg [RISE_N];
   poadc_smp_t rise_next [RISE_N];
   poadc_smp_t fpipe_reg [FALL_N];
   poadc_smp_t fpipe_next [FALL_N];

   always_comb begin
      rise_next[0] = fall_reg;
      for (int k = 1; k < RISE_N; k++) begin
         rise_next[k] = fpipe_reg[k-1];
      end
      for (int k = 0; k < FALL_N; k++) begin
         fpipe_next[k] = rise_reg[k];
      end
      if (sleep_s) begin
         // Powered down: stages stop and drop their samples, so no stale word is marked valid after wake
         for (int k = 0; k < RISE_N; k++) begin
            rise_next[k]       = rise_reg[k];
            rise_next[k].valid = 1'b0;
         end
         for (int k = 0; k < FALL_N; k++) begin
            fpipe_next[k]       = fpipe_reg[k];
            fpipe_next[k].valid = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int k = 0; k < RISE_N; k++) begin
            rise_reg[k] <= '0;
         end
      end else begin
         for (int k = 0; k < RISE_N; k++) begin
            rise_reg[k] <= rise_next[k];
         end
      end
   end

   always_ff @(negedge core_clk) begin
      if (!rstn) begin
         for (int k = 0; k < FALL_N; k++) begin
            fpipe_reg[k] <= '0;
         end
      end else begin
         for (int k = 0; k < FALL_N; k++) begin
            fpipe_reg[k] <= fpipe_next[k];
         end
      end
   end

   // Output latch on rising edge: corrected code, held in power-down
   logic [CODE_W-1:0] code_reg, code_next;
   logic              valid_reg, valid_next;
   poadc_smp_t        last_smp;
   assign last_smp = rise_reg[RISE_N-1];

   always_comb begin
      code_next  = code_reg;
      valid_next = valid_reg;
      if (mode == POADC_RUN) begin
         code_next  = poadc_correct(last_smp.dec);
         valid_next = last_smp.valid;
      end else begin
         valid_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         code_reg  <= CODE_RESET;
         valid_reg <= 1'b0;
      end else begin
         code_reg  <= code_next;
         valid_reg <= valid_next;
      end
   end

   // Bus drive: MSB on bit 9, enable low while driving
   assign sample_code_bus  = code_reg;
   assign sample_code_oe_n = {CODE_W{oen_s}};
   assign sample_valid     = valid_reg;

   // Assertions
   property p_float_when_both_high;
      @(posedge core_clk) disable iff (!rstn)
      (sleep_s && oen_s) |-> (&sample_code_oe_n);
   endproperty
   a_float_when_both_high: assert property (p_float_when_both_high)
      else $error("Bus not floated with sleep and disable");

   property p_drive_follows_enable;
      @(posedge core_clk) disable iff (!rstn)
      !oen_s |-> (sample_code_oe_n == '0);
   endproperty
   a_drive_follows_enable: assert property (p_drive_follows_enable)
      else $error("Bus not driven with enable low");

   property p_hold_in_sleep;
      @(posedge core_clk) disable iff (!rstn)
      (sleep_s && $past(sleep_s)) |-> $stable(sample_code_bus);
   endproperty
   a_hold_in_sleep: assert property (p_hold_in_sleep)
      else $error("Output word changed during power-down");

   property p_no_valid_in_sleep;
      @(posedge core_clk) disable iff (!rstn)
      sleep_s |=> !sample_valid;
   endproperty
   a_no_valid_in_sleep: assert property (p_no_valid_in_sleep)
      else $error("Valid word during power-down");

   property p_latency;
      @(posedge core_clk) disable iff (!rstn)
      fall_reg.valid ##0 (!sleep_s [*6]) |=> (sample_code_bus == poadc_correct($past(fall_reg.dec, 6)));
   endproperty
   a_latency: assert property (p_latency)
      else $error("Code not presented after pipeline latency");

   property p_midscale;
      @(posedge core_clk) disable iff (!rstn)
      (mode == POADC_RUN && last_smp.dec == {NUM_STAGES{DEC_MID}}) |=> (sample_code_bus == CODE_RESET);
   endproperty
   a_midscale: assert property (p_midscale)
      else $error("Bipolar zero not midscale");

   property p_refill;
      @(posedge core_clk) disable iff (!rstn)
      $fell(sleep_s) |-> !sample_valid [*4];
   endproperty
   a_refill: assert property (p_refill)
      else $error("Valid before pipeline refilled");

   property p_code_in_run;
      @(posedge core_clk) disable iff (!rstn)
      (mode == POADC_RUN) |=> (sample_code_bus == poadc_correct($past(last_smp.dec)));
   endproperty
   a_code_in_run: assert property (p_code_in_run)
      else $error("Output word not updated at rising edge");

   c_run_valid:  cover property (@(posedge core_clk) disable iff (!rstn) sample_valid [*4]);
   c_hold:       cover property (@(posedge core_clk) disable iff (!rstn) mode == POADC_HOLD ##1 mode == POADC_HOLD);
   c_float:      cover property (@(posedge core_clk) disable iff (!rstn) mode == POADC_FLOAT);
   c_wake:       cover property (@(posedge core_clk) disable iff (!rstn) $fell(sleep_s) ##[1:20] sample_valid);
endmodule

//--- common/poadc_pkg.sv
// Package for the pipelined converter output port: constants and carried types
package poadc_pkg;
   localparam int unsigned CODE_W      = 10;            // Output code width
   localparam int unsigned NUM_STAGES  = 10;            // Pipeline stages, one bit each
   localparam int unsigned STAGE_BITS  = 2;             // 1.5-bit stage decision width
   localparam int unsigned LAT_HALF    = 11;            // Latency in half cycles (5.5 cycles)
   localparam int unsigned CODE_MSB    = CODE_W - 1;    // Bit index of the MSB on the bus
   localparam logic [CODE_W-1:0] CODE_RESET = 10'h200;  // Midscale, bipolar zero
   localparam logic [1:0] DEC_LOW  = 2'h0;              // Stage decision -1
   localparam logic [1:0] DEC_MID  = 2'h1;              // Stage decision 0
   localparam logic [1:0] DEC_HIGH = 2'h2;              // Stage decision +1

   // Redundant decisions of all stages for one sample, stage 0 first
   typedef logic [NUM_STAGES-1:0][STAGE_BITS-1:0] poadc_dec_t;

   // One sample travelling down the half-cycle pipeline
   typedef struct packed {
      logic       valid;
      poadc_dec_t dec;
   } poadc_smp_t;

   // Operating mode from the sleep and drive-enable pins
   typedef enum logic [1:0] {
      POADC_RUN,
      POADC_HOLD,
      POADC_FLOAT
   } poadc_mode_t;
endpackage

//--- bench/poadc_capture_model.sv
// Downstream capture logic that takes converter words off the three-state bus
`timescale 1ns/1ps
module poadc_capture_model
   import poadc_pkg::*;
(
   input  wire logic                         core_clk,  // Conversion clock
   input  wire logic [poadc_pkg::CODE_W-1:0] code_pins, // Levels the converter drives
   input  wire logic [poadc_pkg::CODE_W-1:0] code_oe_n, // Per-bit drive enable, low = driving
   input  wire logic                         word_ok,   // Converter marks a filled pipeline
   output logic      [poadc_pkg::CODE_W-1:0] cap_word,  // Last word taken in
   output logic                              cap_ok,    // Last word was driven and valid
   output logic                              bus_float  // No bit of the bus is driven
);
   logic [CODE_W-1:0] held = '0;
   logic [CODE_W-1:0] wire_lvl;
   // Undriven bits have no pull, so they show the inverse of the last level
   assign wire_lvl = (~code_oe_n & code_pins) | (code_oe_n & ~held);
   assign bus_float = &code_oe_n;
   // Words are taken at the rising edge; cap_ok needs word_ok and every bit driven
   always_ff @(posedge core_clk) begin
      held <= wire_lvl;
      cap_word <= wire_lvl;
      cap_ok <= word_ok && (code_oe_n == '0);
   end
endmodule

//--- bench/poadc_output_port_tb.sv
// Testbench for the converter output port: codes, latency, sleep hold and float
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module poadc_output_port_tb;
   import poadc_pkg::*;
   logic              core_clk;
   logic              rstn;
   poadc_dec_t        stage_dec;
   logic              sleep_request;
   logic              drive_en_n;
   logic [CODE_W-1:0] sample_code_bus;
   logic [CODE_W-1:0] sample_code_oe_n;
   logic              sample_valid;
   logic [CODE_W-1:0] cap_word;
   logic              cap_ok;
   logic              bus_float;
   int                miscompares;
   int                n_tests;

   poadc_output_port i_dut (.core_clk(core_clk), .rstn(rstn), .stage_dec(stage_dec),
      .sleep_request(sleep_request), .drive_en_n(drive_en_n), .sample_code_bus(sample_code_bus),
      .sample_code_oe_n(sample_code_oe_n), .sample_valid(sample_valid));
   poadc_capture_model i_cap (.core_clk(core_clk), .code_pins(sample_code_bus), .code_oe_n(sample_code_oe_n),
      .word_ok(sample_valid), .cap_word(cap_word), .cap_ok(cap_ok), .bus_float(bus_float));

   // Clock at 50 MHz
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Expected code: midscale plus signed stage weights, clipped to the code range
   function automatic logic [CODE_W-1:0] exp_code(poadc_dec_t d);
      int acc;
      acc = 512;
      for (int i = 0; i < NUM_STAGES; i++) begin
         if (d[i] == DEC_HIGH) acc += 1 << (9 - i);
         if (d[i] == DEC_LOW) acc -= 1 << (9 - i);
      end
      acc = (acc < 0) ? 0 : (acc > 1023) ? 1023 : acc;
      return acc[CODE_W-1:0];
   endfunction

   task automatic put(poadc_dec_t d, logic slp, logic en_n);
      @(negedge core_clk);
      stage_dec = d;
      sleep_request = slp;
      drive_en_n = en_n;
   endtask

   task automatic settle(int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Every coding corner, redundant pairs, and the unused decision value
   task automatic t_codes();
      poadc_dec_t tab[9] = '{20'h55555, 20'haaaaa, 20'h00000, 20'h15555, 20'h40000,
                             20'h25555, 20'h95555, 20'h55556, 20'hfffff};
      foreach (tab[k]) begin
         put(tab[k], 1'b0, 1'b0);
         settle(10);
         `CHK("code", exp_code(tab[k]), sample_code_bus)
         `CHK("captured", exp_code(tab[k]), cap_word)
         `CHK("valid", 1'b1, cap_ok)
      end
      $display("done codes");
   endtask

   // Rising edges from input change to new code: 2 sync plus 6 (half a cycle to the falling-edge capture, then 5.5 cycles)
   task automatic t_latency();
      int n;
      put(20'h55555, 1'b0, 1'b0);
      settle(10);
      put(20'h55559, 1'b0, 1'b0);
      for (n = 1; n <= 20; n++) begin
         @(posedge core_clk);
         #1;
         if (sample_code_bus === exp_code(20'h55559)) break;
      end
      `CHK("latency", 2 + (LAT_HALF + 1) / 2, n)
      if (n > 20) wrap_up();
      $display("done latency");
   endtask

   // Sleep with drive on holds the last word; wake converts again
   task automatic t_sleep();
      put(20'h25555, 1'b0, 1'b0);
      settle(10);
      put(20'h00000, 1'b1, 1'b0);
      settle(14);
      `CHK("held", 10'h201, sample_code_bus)
      `CHK("oe held", 10'h000, sample_code_oe_n)
      `CHK("sleep valid", 1'b0, sample_valid)
      put(20'h00000, 1'b0, 1'b0);
      settle(12);
      `CHK("wake", 10'h000, sample_code_bus)
      `CHK("wake capture", 1'b1, cap_ok)
      $display("done sleep");
   endtask

   // Drive enable high floats the bus, awake or asleep
   task automatic t_float();
      put(20'h55555, 1'b1, 1'b1);
      settle(4);
      `CHK("float sleep", 10'h3ff, sample_code_oe_n)
      `CHK("float seen", 1'b1, bus_float)
      put(20'h55555, 1'b0, 1'b1);
      settle(12);
      `CHK("float awake", 10'h3ff, sample_code_oe_n)
      `CHK("no capture", 1'b0, cap_ok)
      put(20'h55555, 1'b0, 1'b0);
      settle(4);
      `CHK("driven", 10'h000, sample_code_oe_n)
      $display("done float");
   endtask

   // Reset, then the scenarios
   initial begin
      miscompares = 0;
      n_tests = 0;
      rstn = 1'b0;
      stage_dec = 20'h55555;
      sleep_request = 1'b0;
      drive_en_n = 1'b0;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      `CHK("reset code", CODE_RESET, sample_code_bus)
      `CHK("reset oe", 10'h3ff, sample_code_oe_n)
      // Non-blocking so the falling-edge stages still see reset at this edge
      rstn <= 1'b1;
      t_codes();
      t_latency();
      t_sleep();
      t_float();
      wrap_up();
   end
endmodule
